// >>> rtl/tsx_exec.sv
`timescale 1ns/1ps
`include "tsx_defs.svh"
// Functional notes
// [RULE1] Opcode 0110011a plus 8-bit address is test-skip-if-zero; flags untouched.
// [RULE2] Zero register: drop prefetched word, run one NOP cycle, two cycles.
// [RULE3] Skipping a two-word instruction adds two NOP cycles, three total.
// [RULE4] Skipping a three-word instruction adds three NOP cycles, four total.
// [RULE5] Access bit 0 uses access bank; 1 takes upper bits from bank select.
// [RULE6] Extended set, access bit 0, address at most 95: indexed literal offset.
// [RULE7] Table write reads latch in second cycle, writes holding register late.
// [RULE8] Post-increment writes then bumps pointer; pre-increment bumps then writes.
// [RULE9] Pointer is 21 bits; modes none, post-inc, post-dec, pre-inc.
// [RULE10] Pointer bit 0 picks byte: 0 low byte, 1 high byte.
// [RULE11] Zero only if all bits clear; otherwise single cycle, no skip.
// [RULE12] Test cycle: decode Q1, read Q2, evaluate Q3, nothing in Q4.
module tsx_exec
   import tsx_pkg::*;
#(
   parameter int DADDR_W = 14,
   parameter int BSR_W = 6,
   parameter int PTR_W = 21
)
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [1:0] i_next_words,
   input wire logic i_ext_en,
   input wire logic [BSR_W-1:0] i_bsr,
   input wire logic [DADDR_W-1:0] i_fsr2,
   input wire logic [7:0] i_rd_data,
   input wire logic [7:0] i_table_latch,
   input wire logic i_ptr_load,
   input wire logic [PTR_W-1:0] i_ptr_value,
   output tsx_rd_req_t o_rd,
   output tsx_hold_wr_t o_hold,
   output logic [PTR_W-1:0] o_table_pointer,
   output logic o_nop,
   output logic o_busy,
   output logic o_flags_we
);
   // ***********************************************
   // Checks and phase
   // ***********************************************
   if (DADDR_W != BSR_W + 8 || PTR_W != 21 || DADDR_W != 14)
   begin : g_bad
      $error("tsx_exec: widths not supported");
   end

   tsx_phase_t phase;
   tsx_state_t state;
   tsx_state_t next_state;
   logic [1:0] mode;
   logic [1:0] skip_cnt;
   logic [7:0] rd_byte;
   logic [7:0] tl_byte;
   logic is_zero;
   logic accept;
   logic is_tst;
   logic is_tw;

   tsx_qphase u_qphase (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .o_phase(phase)
   );

   // Operand address; the extended test only applies with the access bit clear
   function automatic logic [13:0] tsx_operand_addr(input logic a, input logic [7:0] f,
      input logic ext, input logic [5:0] bank_select_register, input logic [13:0] fsr2);
      logic [13:0] r;
      r = {6'h3F, f};
      if (a)
         r = {bank_select_register, f}; // [RULE5]
      else if (ext && f <= `TSX_LIT_MAX)
         r = 14'(fsr2 + {6'h00, f}); // [RULE6]
      else if (f < `TSX_ACC_SPLIT)
         r = {6'h00, f}; // [RULE5]
      return r;
   endfunction

   // ***********************************************
   // Decode and sequencing
   // ***********************************************
   assign is_tst = i_instr[15:9] == `TSX_TST_OP; // [RULE1]
   assign is_tw = i_instr[15:2] == `TSX_TABLE_WRITE_INSTRUCTION_OP;
   assign accept = i_instr_valid && phase == TSX_Q1 && state == TSX_IDLE;

   // Next state; words while busy are ignored by design
   always_comb
   begin
      next_state = state;
      case (state)
         TSX_IDLE:
            if (accept && is_tst)
               next_state = TSX_TEST;
            else if (accept && is_tw)
               next_state = TSX_TW1;
         TSX_TEST:
            if (phase == TSX_Q4)
               next_state = is_zero ? TSX_SKIP : TSX_IDLE; // [RULE2] [RULE11]
         TSX_SKIP:
            if (phase == TSX_Q4 && skip_cnt == `TSX_SKIP_ONE)
               next_state = TSX_IDLE; // [RULE3] [RULE4]
         TSX_TW1:
            if (phase == TSX_Q4)
               next_state = TSX_TW2;
         TSX_TW2:
            if (phase == TSX_Q4)
               next_state = TSX_IDLE;
         default:
            next_state = TSX_IDLE;
      endcase
   end

   // State and status strobes; flags are never written by either instruction
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state <= TSX_IDLE;
         o_busy <= 1'b0;
         o_nop <= 1'b0;
         o_flags_we <= 1'b0;
      end
      else
      begin
         state <= next_state;
         o_busy <= next_state != TSX_IDLE;
         o_nop <= next_state == TSX_SKIP; // Fetch logic drops the prefetched word
         o_flags_we <= 1'b0; // [RULE1]
      end
   end

   // ***********************************************
   // Test register, skip if zero
   // ***********************************************
   // Read request in Q2, data captured at the end of Q2
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_rd <= '0;
         rd_byte <= `TSX_BYTE_RST;
      end
      else if (accept && is_tst)
      begin
         o_rd.en <= 1'b1; // [RULE12]
         o_rd.addr <= tsx_operand_addr(i_instr[8], i_instr[7:0], i_ext_en, i_bsr, i_fsr2);
      end
      else if (state == TSX_TEST && phase == TSX_Q2)
      begin
         o_rd.en <= 1'b0;
         rd_byte <= i_rd_data; // [RULE12]
      end
   end

   // Evaluate in Q3; Q4 writes nothing back
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         is_zero <= 1'b0;
      else if (state == TSX_TEST && phase == TSX_Q3)
         is_zero <= rd_byte == `TSX_BYTE_RST; // [RULE11] [RULE12]
   end

   // NOP cycles follow the size of the skipped instruction; zero words treated as one
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         skip_cnt <= `TSX_SKIP_RST;
      else if (state == TSX_TEST && phase == TSX_Q4)
         skip_cnt <= (i_next_words == `TSX_SKIP_RST) ? `TSX_SKIP_ONE : i_next_words; // [RULE3]
      else if (state == TSX_SKIP && phase == TSX_Q4)
         skip_cnt <= 2'(skip_cnt - `TSX_SKIP_ONE); // [RULE4]
   end

   // ***********************************************
   // Table write tail
   // ***********************************************
   // Address mode held for the whole table write
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         mode <= `TSX_MODE_NONE;
      else if (accept && is_tw)
         mode <= i_instr[1:0]; // [RULE9]
   end

   // Latch sampled in Q2 of the second cycle
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         tl_byte <= `TSX_BYTE_RST;
      else if (state == TSX_TW2 && phase == TSX_Q2)
         tl_byte <= i_table_latch; // [RULE7]
   end

   // Pointer: pre-increment in Q1, write and post update in Q4
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         o_table_pointer <= `TSX_PTR_RST;
      else if (state == TSX_TW2 && ((phase == TSX_Q1 && mode == `TSX_MODE_PRE_INC) ||
         (phase == TSX_Q4 && mode == `TSX_MODE_POST_INC)))
         o_table_pointer <= o_table_pointer + `TSX_PTR_ONE; // [RULE8]
      else if (state == TSX_TW2 && phase == TSX_Q4 && mode == `TSX_MODE_POST_DEC)
         o_table_pointer <= o_table_pointer - `TSX_PTR_ONE; // [RULE9]
      else if (i_ptr_load && state == TSX_IDLE)
         o_table_pointer <= i_ptr_value; // Core load only between instructions
   end

   // Holding register write, one clock pulse after Q4 of the second cycle
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         o_hold <= '0;
      else if (state == TSX_TW2 && phase == TSX_Q4)
      begin
         o_hold.we <= 1'b1; // [RULE7]
         o_hold.addr <= o_table_pointer; // [RULE8]
         o_hold.hi <= o_table_pointer[0]; // [RULE10]
         o_hold.data <= tl_byte;
      end
      else
         o_hold.we <= 1'b0;
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   logic [3:0] nop_len;
   logic [1:0] words_seen;
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         nop_len <= 4'h0;
         words_seen <= `TSX_SKIP_RST;
      end
      else
      begin
         nop_len <= o_nop ? 4'(nop_len + 4'h1) : 4'h0;
         if (state == TSX_TEST && phase == TSX_Q4)
            words_seen <= skip_cnt == `TSX_SKIP_RST ? i_next_words : i_next_words;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   a_flags_unchanged: assert property (!o_flags_we) // [RULE1]
      else $error("status write seen");
   a_read_in_q2: assert property (state == TSX_TEST && phase == TSX_Q2 |-> o_rd.en) // [RULE12]
      else $error("no register read in Q2");
   a_test_single: assert property ($rose(state == TSX_TEST) |->
      (state == TSX_TEST)[*3] ##1 state != TSX_TEST) // [RULE11]
      else $error("test cycle length wrong");
   a_skip_one_word: assert property (state == TSX_TEST && phase == TSX_Q4 && is_zero &&
      i_next_words == 2'h1 |-> ##1 o_nop[*4] ##1 !o_nop) // [RULE2]
      else $error("one-word skip not one nop cycle");
   a_skip_two_word: assert property ($fell(o_nop) && words_seen == 2'h2 |->
      $past(nop_len) == 4'h7) // [RULE3]
      else $error("two-word skip length wrong");
   a_skip_three_word: assert property ($fell(o_nop) && words_seen == 2'h3 |->
      $past(nop_len) == 4'hB) // [RULE4]
      else $error("three-word skip length wrong");
   a_no_skip_nonzero: assert property (state == TSX_TEST && phase == TSX_Q4 && !is_zero
      |=> !o_nop && state == TSX_IDLE) // [RULE11]
      else $error("skip on nonzero register");
   a_bank_select: assert property (accept && is_tst && i_instr[8] |=>
      o_rd.addr == {$past(i_bsr), $past(i_instr[7:0])}) // [RULE5]
      else $error("bank select address wrong");
   a_literal_offset: assert property (accept && is_tst && !i_instr[8] && i_ext_en &&
      i_instr[7:0] <= 8'h5F |=> o_rd.addr == 14'($past(i_fsr2) + $past(i_instr[7:0]))) // [RULE6]
      else $error("indexed literal address wrong");
   a_hold_timing: assert property ($rose(state == TSX_TW2) |->
      ##4 (o_hold.we && o_hold.data == tl_byte)) // [RULE7]
      else $error("holding write late or wrong");
   a_post_inc: assert property (o_hold.we && mode == `TSX_MODE_POST_INC |->
      o_table_pointer == o_hold.addr + `TSX_PTR_ONE) // [RULE8]
      else $error("post-increment wrong");
   a_pre_inc: assert property (o_hold.we && mode == `TSX_MODE_PRE_INC |->
      o_hold.addr == o_table_pointer && o_hold.addr == $past(o_table_pointer, 4)
      + `TSX_PTR_ONE) // [RULE8]
      else $error("pre-increment wrong");
   a_post_dec: assert property (o_hold.we && mode == `TSX_MODE_POST_DEC |->
      o_table_pointer == o_hold.addr - `TSX_PTR_ONE) // [RULE9]
      else $error("post-decrement wrong");
   a_byte_select: assert property (o_hold.we |-> o_hold.hi == $past(o_table_pointer[0])) // [RULE10]
      else $error("byte select wrong");

   c_skip_one: cover property ($fell(o_nop) && words_seen == 2'h1);
   c_skip_three: cover property ($fell(o_nop) && words_seen == 2'h3);
   c_tw_post: cover property (o_hold.we && mode == `TSX_MODE_POST_INC);
   c_tw_pre: cover property (o_hold.we && mode == `TSX_MODE_PRE_INC);
endmodule

// >>> rtl/tsx_defs.svh
`ifndef TSX_DEFS_SVH
`define TSX_DEFS_SVH
// Opcode patterns
`define TSX_TST_OP 7'h33
`define TSX_TABLE_WRITE_INSTRUCTION_OP 14'h0003
// Access bank split and literal offset limit
`define TSX_ACC_SPLIT 8'h60
`define TSX_LIT_MAX 8'h5F
// Table write address modes
`define TSX_MODE_NONE 2'h0
`define TSX_MODE_POST_INC 2'h1
`define TSX_MODE_POST_DEC 2'h2
`define TSX_MODE_PRE_INC 2'h3
// Reset values and unit step constants
`define TSX_PTR_RST 21'h0_0000
`define TSX_PTR_ONE 21'h0_0001
`define TSX_BYTE_RST 8'h00
`define TSX_SKIP_RST 2'h0
`define TSX_SKIP_ONE 2'h1
`endif

// >>> rtl/tsx_pkg.sv
package tsx_pkg;
   typedef enum logic [1:0] {
      TSX_Q1 = 2'b00,
      TSX_Q2 = 2'b01,
      TSX_Q3 = 2'b10,
      TSX_Q4 = 2'b11
   } tsx_phase_t;
   typedef enum logic [2:0] {
      TSX_IDLE = 3'b000,
      TSX_TEST = 3'b001,
      TSX_SKIP = 3'b010,
      TSX_TW1 = 3'b011,
      TSX_TW2 = 3'b100
   } tsx_state_t;
   typedef struct packed {
      logic en;
      logic [13:0] addr;
   } tsx_rd_req_t;
   typedef struct packed {
      logic we;
      logic hi;
      logic [20:0] addr;
      logic [7:0] data;
   } tsx_hold_wr_t;
endpackage

// >>> rtl/tsx_qphase.sv
`timescale 1ns/1ps
// Four-phase sequencer of the instruction cycle
module tsx_qphase
   import tsx_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   output tsx_phase_t o_phase
);
   // Free running, Q1 after reset so a first instruction is taken at once
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         o_phase <= TSX_Q1;
      else
         o_phase <= tsx_phase_t'(o_phase + 2'b01);
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "tsx_defs.svh"
module tb_top
   import tsx_pkg::*;
;
   logic i_clk_sys = 1'b0;
   logic i_nrst = 1'b0;
   logic i_instr_valid = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic [1:0] i_next_words = 2'h1;
   logic i_ext_en = 1'b0;
   logic [5:0] i_bsr = 6'h2A;
   logic [13:0] i_fsr2 = 14'h0123;
   logic [7:0] i_rd_data = 8'h00;
   logic [7:0] i_table_latch = 8'h00;
   logic i_ptr_load = 1'b0;
   logic [20:0] i_ptr_value = 21'h0_0000;
   tsx_rd_req_t o_rd;
   tsx_hold_wr_t o_hold;
   logic [20:0] o_table_pointer;
   logic o_nop;
   logic o_busy;
   logic o_flags_we;
   int n_errors = 0;
   int n_tests = 0;
   int ph = 0;
   int cycles = 0;
   tsx_exec i_tsx_exec (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_next_words(i_next_words), .i_ext_en(i_ext_en), .i_bsr(i_bsr),
      .i_fsr2(i_fsr2), .i_rd_data(i_rd_data), .i_table_latch(i_table_latch),
      .i_ptr_load(i_ptr_load), .i_ptr_value(i_ptr_value), .o_rd(o_rd), .o_hold(o_hold),
      .o_table_pointer(o_table_pointer), .o_nop(o_nop), .o_busy(o_busy),
      .o_flags_we(o_flags_we));
   // ***********************************
   // Clock, phase tracking and time limit
   // ***********************************
   // 40 ns period
   initial
   begin
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   // Edge count since release; edge 4k is a Q1 edge
   always @(posedge i_clk_sys)
   begin
      if (i_nrst) ph <= ph + 1;
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Waits n edges, then lets that edge's updates land
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // Presents a word on a Q4 edge so the next Q1 edge takes it; returns at that Q1 edge
   task automatic issue(input logic [15:0] ins, input logic [7:0] d, input logic [1:0] nw,
                        input logic ext);
      do @(posedge i_clk_sys); while (ph % 4 != 3);
      i_instr <= ins;
      i_instr_valid <= 1'b1;
      i_rd_data <= d;
      i_table_latch <= d;
      i_next_words <= nw;
      i_ext_en <= ext;
      @(posedge i_clk_sys);
      i_instr_valid <= 1'b0;
   endtask
   // ***********************************
   // Scenarios
   // ***********************************
   // Test-and-skip with full walk of read request and skip length
   task automatic run_tst(input logic a, input logic [7:0] f, input logic ext,
                          input logic [7:0] rd, input logic [1:0] nw);
      logic [13:0] ea;
      int n;
      if (a) ea = {i_bsr, f};
      else if (ext && f <= 8'h5F) ea = i_fsr2 + {6'h00, f};
      else if (f < 8'h60) ea = {6'h00, f};
      else ea = {6'h3F, f};
      n = (rd != 8'h00) ? 0 : 4 * ((nw == 2'h0) ? 1 : int'(nw));
      issue({`TSX_TST_OP, a, f}, rd, nw, ext);
      #1;
      chk("rd_en", o_rd.en, 1);
      chk("rd_addr", o_rd.addr, ea);
      chk("busy", o_busy, 1);
      tick(1);
      chk("rd_en_drop", o_rd.en, 0);
      tick(2);
      chk("nop_start", o_nop, n != 0);
      chk("busy_q4", o_busy, n != 0);
      chk("flags_we", o_flags_we, 0);
      if (n != 0)
      begin
         tick(n - 1);
         chk("nop_hold", o_nop, 1);
         tick(1);
         chk("nop_end", o_nop, 0);
         chk("busy_end", o_busy, 0);
      end
   endtask
   // Table write with pointer load and address-mode update
   task automatic run_tw(input logic [1:0] m, input logic [20:0] p, input logic [7:0] d);
      logic [20:0] wa;
      logic [20:0] fin;
      wa = (m == `TSX_MODE_PRE_INC) ? p + 21'h0_0001 : p;
      fin = (m == `TSX_MODE_POST_DEC) ? p - 21'h0_0001 : (m == `TSX_MODE_NONE) ? p : p + 21'h0_0001;
      @(posedge i_clk_sys);
      i_ptr_load <= 1'b1;
      i_ptr_value <= p;
      @(posedge i_clk_sys);
      i_ptr_load <= 1'b0;
      #1;
      chk("ptr_load", o_table_pointer, p);
      issue({`TSX_TABLE_WRITE_INSTRUCTION_OP, m}, d, 2'h1, 1'b0);
      #1;
      chk("tw_busy", o_busy, 1);
      tick(4);
      chk("ptr_pre", o_table_pointer, (m == `TSX_MODE_PRE_INC) ? p + 21'h0_0001 : p);
      tick(2);
      chk("we_early", o_hold.we, 0);
      tick(1);
      chk("we", o_hold.we, 1);
      chk("hold_addr", o_hold.addr, wa);
      chk("hold_hi", o_hold.hi, wa[0]);
      chk("hold_data", o_hold.data, d);
      chk("ptr_fin", o_table_pointer, fin);
      chk("tw_done", o_busy, 0);
      tick(1);
      chk("we_pulse", o_hold.we, 0);
   endtask
   // Unknown word must leave the block idle
   task automatic run_bad();
      issue(16'hFFFF, 8'h00, 2'h1, 1'b0);
      tick(3);
      chk("bad_busy", o_busy, 0);
      chk("bad_rd", o_rd.en, 0);
   endtask
   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      run_tst(1'b1, 8'h45, 1'b0, 8'h80, 2'h1);
      run_tst(1'b0, 8'h5F, 1'b1, 8'h01, 2'h1);
      run_tst(1'b0, 8'h60, 1'b1, 8'h00, 2'h2);
      run_tst(1'b0, 8'h10, 1'b0, 8'h00, 2'h3);
      run_tst(1'b1, 8'hFF, 1'b1, 8'h00, 2'h1);
      run_tst(1'b0, 8'h20, 1'b1, 8'h00, 2'h0);
      run_bad();
      for (int m = 0; m < 4; m++)
         run_tw(2'(m), 21'h0_A356 + 21'(m), 8'h55 + 8'(m));
      run_tw(`TSX_MODE_POST_INC, 21'h1F_FFFF, 8'h34);
      run_tw(`TSX_MODE_POST_DEC, 21'h0_0000, 8'hA5);
      stop_test();
   end
endmodule
